// file: src/charger_serial_port.sv
// Serial slave port and status/control registers of the charger
//
// Function
// RL1 - Answer only to seven-bit address 6Bh, standard and fast rates.
// RL2 - Start is SDA falling with SCL high; restarts address recognition.
// RL3 - Master sends seven address bits then the direction bit.
// RL4 - SDA stays stable while SCL is high; changes only when low.
// RL5 - Acknowledge a matching address by holding SDA low in ninth cycle.
// RL6 - Direction 0 writes to device, direction 1 reads from it.
// RL7 - Each byte is eight bits plus receiver acknowledge, repeating freely.
// RL8 - Master ends a transfer with SDA rising while SCL high.
// RL9 - On stop the port drops the transaction and waits for start.
// RL10 - An abandoned transfer is closed with a stop by the master.
// RL11 - Reads of unimplemented register addresses return FFh.
// RL12 - First written byte selects the register; later bytes load it.
// RL13 - Status bit 7 write of 1 kicks the watchdog; reads 0.
// RL14 - Status bit 6 selects boost mode; resets to charge mode.
// RL15 - Status bits 5:4 show the live charge state.
// RL16 - Status bits 2:0 are a read-only fault code.
// RL17 - Fault code holds the first fault and clears on read.
// RL18 - Control bit 7 write of 1 resets all registers; reads 1.
// RL19 - Soft reset enters default mode and turns the watchdog off.
// RL20 - Control bits 6:4 select the input current limit.
// RL21 - In default mode the limit follows the detected source.
// RL22 - Control bit 3 enables progress indication; default 1.
// RL23 - Control bit 2 enables end-of-charge current cutoff; default 1.
// RL24 - Control bit 1 set stops charging; default 0.
// RL25 - Control bit 0 set selects input off state; default 0.
// RL26 - A fault in boost mode clears the boost bit.
`timescale 1ns/1ps
`default_nettype none

module charger_serial_port
	import charger_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [1:0] charge_state_i,
	input wire logic fault_event_i,
	input wire logic [2:0] fault_code_i,
	input wire logic [2:0] detected_limit_i,
	output logic watchdog_kick_o,
	output logic watchdog_off_o,
	output logic default_mode_o,
	output logic boost_mode_o,
	output logic [2:0] input_limit_o,
	output logic stat_enable_o,
	output logic end_of_charge_cutoff_on_o,
	output logic charge_disable_o,
	output logic input_off_select_o,
	output logic [2:0] fault_code_o
);
	// Link-side signals
	logic scl_s, sda_s, rst_l, en_l;
	logic scl_prev_reg, sda_prev_reg;
	logic start_det, stop_det, scl_rise, scl_fall;
	link_state_type state_reg;
	logic [3:0] count_reg;
	logic [7:0] shift_reg;
	logic dir_read_reg, first_byte_reg, nack_reg, sda_oe_reg;
	logic wr_tgl_reg, wr_is_ptr_reg, rd_tgl_reg;
	logic [7:0] wr_byte_reg;

	// System-side signals
	logic wr_tgl_s, rd_tgl_s, wr_seen_reg, rd_seen_reg;
	logic [2:0] det_limit_s;
	logic wr_evt, rd_evt, ptr_wr, data_wr, wr_status, wr_control, soft_rst;
	logic [7:0] ptr_reg, rd_data_reg, rd_value;
	logic boost_reg, kick_reg, wd_off_reg, default_reg;
	logic stat_en_reg, cutoff_reg, chg_off_reg, input_off_reg;
	logic [2:0] limit_reg;

	// Link domain: bus lines, reset and enable all arrive from outside it
	sync_2ff #(.WIDTH(4)) u_link_sync (
		.clk_i(link_clk_i),
		.d_i({scl_i, sda_i, sys_rst_i, clk_en_i}),
		.q_o({scl_s, sda_s, rst_l, en_l})
	);

	always_ff @(posedge link_clk_i) begin
		if (rst_l) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else if (en_l) begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	// Edges of SDA with SCL held high frame every transfer
	assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // RL2
	assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // RL9
	assign scl_rise = scl_s & ~scl_prev_reg;
	assign scl_fall = ~scl_s & scl_prev_reg;

	// Byte engine: samples on SCL rise, changes SDA only after SCL falls
	always_ff @(posedge link_clk_i) begin
		if (rst_l) begin
			state_reg <= LINK_IDLE;
			count_reg <= COUNT_RST;
			shift_reg <= BYTE_RST;
			dir_read_reg <= 1'b0;
			first_byte_reg <= 1'b0;
			nack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			wr_tgl_reg <= 1'b0;
			wr_is_ptr_reg <= 1'b0;
			wr_byte_reg <= BYTE_RST;
			rd_tgl_reg <= 1'b0;
		end else if (en_l) begin
			if (stop_det) begin
				state_reg <= LINK_IDLE; // RL9
				sda_oe_reg <= 1'b0; // RL9
			end else if (start_det) begin
				state_reg <= LINK_ADDR; // RL2
				count_reg <= COUNT_RST; // RL2
				sda_oe_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					LINK_IDLE: begin
						sda_oe_reg <= 1'b0;
					end
					LINK_ADDR: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							count_reg <= count_reg + 4'h1;
						end else if (scl_fall && count_reg == BYTE_BITS) begin
							if (shift_reg[7:1] == SLAVE_ADDR) begin // RL1
								sda_oe_reg <= 1'b1; // RL5
								dir_read_reg <= shift_reg[0]; // RL6
								state_reg <= LINK_ADDR_ACK;
							end else begin
								state_reg <= LINK_IDLE; // RL5
							end
						end
					end
					LINK_ADDR_ACK: begin
						if (scl_rise && dir_read_reg) begin
							rd_tgl_reg <= ~rd_tgl_reg;
						end else if (scl_fall) begin
							count_reg <= COUNT_RST;
							if (dir_read_reg) begin
								shift_reg <= rd_data_reg; // RL6
								sda_oe_reg <= ~rd_data_reg[7];
								state_reg <= LINK_RD_BYTE;
							end else begin
								sda_oe_reg <= 1'b0;
								first_byte_reg <= 1'b1;
								state_reg <= LINK_WR_BYTE;
							end
						end
					end
					LINK_WR_BYTE: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							count_reg <= count_reg + 4'h1;
						end else if (scl_fall && count_reg == BYTE_BITS) begin
							sda_oe_reg <= 1'b1; // RL7
							wr_byte_reg <= shift_reg;
							wr_is_ptr_reg <= first_byte_reg; // RL12
							first_byte_reg <= 1'b0;
							wr_tgl_reg <= ~wr_tgl_reg;
							state_reg <= LINK_WR_ACK;
						end
					end
					LINK_WR_ACK: begin
						if (scl_fall) begin
							sda_oe_reg <= 1'b0;
							count_reg <= COUNT_RST;
							state_reg <= LINK_WR_BYTE; // RL7
						end
					end
					LINK_RD_BYTE: begin
						if (scl_fall) begin
							if (count_reg == LAST_TX_BIT) begin
								sda_oe_reg <= 1'b0;
								state_reg <= LINK_RD_ACK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_oe_reg <= ~shift_reg[6];
								count_reg <= count_reg + 4'h1;
							end
						end
					end
					LINK_RD_ACK: begin
						if (scl_rise) begin
							nack_reg <= sda_s; // RL7
							if (!sda_s) begin
								rd_tgl_reg <= ~rd_tgl_reg;
							end
						end else if (scl_fall) begin
							count_reg <= COUNT_RST;
							if (nack_reg) begin
								state_reg <= LINK_IDLE;
							end else begin
								shift_reg <= rd_data_reg;
								sda_oe_reg <= ~rd_data_reg[7];
								state_reg <= LINK_RD_BYTE;
							end
						end
					end
				endcase
			end
		end
	end

	// Open drain: the pad only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_reg;

	// System domain: toggles mark events, the byte beside them is already stable
	sync_2ff #(.WIDTH(2)) u_evt_sync (
		.clk_i(clock_i),
		.d_i({wr_tgl_reg, rd_tgl_reg}),
		.q_o({wr_tgl_s, rd_tgl_s})
	);

	sync_2ff #(.WIDTH(3)) u_det_sync (
		.clk_i(clock_i),
		.d_i(detected_limit_i),
		.q_o(det_limit_s)
	);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wr_seen_reg <= 1'b0;
			rd_seen_reg <= 1'b0;
		end else if (clk_en_i) begin
			wr_seen_reg <= wr_tgl_s;
			rd_seen_reg <= rd_tgl_s;
		end
	end

	assign wr_evt = clk_en_i & (wr_tgl_s ^ wr_seen_reg);
	assign rd_evt = clk_en_i & (rd_tgl_s ^ rd_seen_reg);
	assign ptr_wr = wr_evt & wr_is_ptr_reg;
	assign data_wr = wr_evt & ~wr_is_ptr_reg;
	assign wr_status = data_wr & (ptr_reg == REG_STATUS);
	assign wr_control = data_wr & (ptr_reg == REG_CONTROL);
	assign soft_rst = wr_control & wr_byte_reg[SOFT_RST_BIT]; // RL18

	// Later data bytes keep loading the same register
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ptr_reg <= REG_STATUS;
		end else if (ptr_wr) begin
			ptr_reg <= wr_byte_reg; // RL12
		end
	end

	// Boost select: a reported fault while boosting wins over a write
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			boost_reg <= BOOST_RST;
		end else if (clk_en_i) begin
			if (soft_rst) begin
				boost_reg <= BOOST_RST; // RL19
			end else if (fault_event_i && boost_reg) begin
				boost_reg <= 1'b0; // RL26
			end else if (wr_status) begin
				boost_reg <= wr_byte_reg[BOOST_BIT]; // RL14
			end
		end
	end

	// Watchdog pulses; the kick bit itself is never stored
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			kick_reg <= 1'b0;
			wd_off_reg <= 1'b0;
		end else if (clk_en_i) begin
			kick_reg <= wr_status & wr_byte_reg[KICK_BIT]; // RL13
			wd_off_reg <= soft_rst; // RL19
		end
	end

	// Default mode lasts until software writes the control register or kicks
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			default_reg <= 1'b1;
		end else if (clk_en_i) begin
			if (soft_rst) begin
				default_reg <= 1'b1; // RL19
			end else if (wr_control || (wr_status && wr_byte_reg[KICK_BIT])) begin
				default_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			stat_en_reg <= STAT_EN_RST;
			cutoff_reg <= CUTOFF_RST;
			chg_off_reg <= CHG_OFF_RST;
			input_off_reg <= INPUT_OFF_RST;
			limit_reg <= LIMIT_RST;
		end else if (clk_en_i) begin
			if (soft_rst) begin
				stat_en_reg <= STAT_EN_RST; // RL18
				cutoff_reg <= CUTOFF_RST;
				chg_off_reg <= CHG_OFF_RST;
				input_off_reg <= INPUT_OFF_RST;
				limit_reg <= det_limit_s; // RL21
			end else if (wr_control) begin
				stat_en_reg <= wr_byte_reg[STAT_EN_BIT]; // RL22
				cutoff_reg <= wr_byte_reg[CUTOFF_BIT]; // RL23
				chg_off_reg <= wr_byte_reg[CHG_OFF_BIT]; // RL24
				input_off_reg <= wr_byte_reg[INPUT_OFF_BIT]; // RL25
				limit_reg <= wr_byte_reg[LIMIT_HI:LIMIT_LO]; // RL20
			end else if (default_reg) begin
				limit_reg <= det_limit_s; // RL21
			end
		end
	end

	fault_code_latch u_fault (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.soft_rst_i(soft_rst),
		.set_i(fault_event_i),
		.code_i(fault_code_i),
		.clear_i(rd_evt && ptr_reg == REG_STATUS),
		.code_o(fault_code_o)
	);

	// Read image of the selected register
	always_comb begin
		rd_value = UNMAPPED_READ; // RL11
		if (ptr_reg == REG_STATUS) begin
			rd_value[KICK_BIT] = KICK_READ; // RL13
			rd_value[BOOST_BIT] = boost_reg;
			rd_value[STATE_HI:STATE_LO] = charge_state_i; // RL15
			rd_value[SPARE_BIT] = SPARE_READ;
			rd_value[FAULT_HI:FAULT_LO] = fault_code_o; // RL16
		end else if (ptr_reg == REG_CONTROL) begin
			rd_value[SOFT_RST_BIT] = SOFT_RST_READ; // RL18
			rd_value[LIMIT_HI:LIMIT_LO] = limit_reg;
			rd_value[STAT_EN_BIT] = stat_en_reg;
			rd_value[CUTOFF_BIT] = cutoff_reg;
			rd_value[CHG_OFF_BIT] = chg_off_reg;
			rd_value[INPUT_OFF_BIT] = input_off_reg;
		end
	end

	// Captured per read request; the link loads it a fraction of a bit later
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rd_data_reg <= UNMAPPED_READ;
		end else if (rd_evt) begin
			rd_data_reg <= rd_value; // RL12
		end
	end

	assign watchdog_kick_o = kick_reg;
	assign watchdog_off_o = wd_off_reg;
	assign default_mode_o = default_reg;
	assign boost_mode_o = boost_reg;
	assign input_limit_o = limit_reg;
	assign stat_enable_o = stat_en_reg;
	assign end_of_charge_cutoff_on_o = cutoff_reg;
	assign charge_disable_o = chg_off_reg;
	assign input_off_select_o = input_off_reg;

	// Checks in the system domain
	kick_pulse_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL13
		wr_status && wr_byte_reg[KICK_BIT]
			|=> watchdog_kick_o ##1 (!watchdog_kick_o || !$past(clk_en_i)))
		else $error("watchdog kick pulse missing");
	boost_drop_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL26
		clk_en_i && fault_event_i && boost_mode_o |=> !boost_mode_o)
		else $error("boost mode kept after fault");
	soft_reset_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL19
		soft_rst |=> default_mode_o && watchdog_off_o && stat_enable_o && !charge_disable_o
			&& end_of_charge_cutoff_on_o && !input_off_select_o && !boost_mode_o
			&& fault_code_o == FAULT_NONE)
		else $error("soft reset left a register off default");
	fault_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL17
		clk_en_i && fault_code_o != FAULT_NONE && !soft_rst
			&& !(rd_evt && ptr_reg == REG_STATUS) |=> $stable(fault_code_o))
		else $error("latched fault code changed without read");
	fault_first_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL17
		clk_en_i && fault_event_i && fault_code_o == FAULT_NONE && !soft_rst
			|=> fault_code_o == $past(fault_code_i))
		else $error("first fault not latched");
	unmapped_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL11
		rd_evt && ptr_reg > REG_CONTROL |=> rd_data_reg == UNMAPPED_READ)
		else $error("unmapped register did not read FFh");
	status_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL15
		rd_evt && ptr_reg == REG_STATUS |=> !rd_data_reg[KICK_BIT]
			&& rd_data_reg[STATE_HI:STATE_LO] == $past(charge_state_i)
			&& rd_data_reg[FAULT_HI:FAULT_LO] == $past(fault_code_o))
		else $error("status read image wrong");
	control_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL18
		rd_evt && ptr_reg == REG_CONTROL |=> rd_data_reg[SOFT_RST_BIT]
			&& rd_data_reg[CHG_OFF_BIT] == $past(charge_disable_o))
		else $error("control read image wrong");
	default_limit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RL21
		clk_en_i && default_mode_o && !wr_control ##1 clk_en_i |-> input_limit_o == $past(det_limit_s))
		else $error("default limit not following detection");

	// Checks in the link domain
	stop_release_a: assert property (@(posedge link_clk_i) disable iff (rst_l) // RL9
		en_l && stop_det |=> !sda_oe_o && state_reg == LINK_IDLE)
		else $error("bus not released after stop");
	addr_nack_a: assert property (@(posedge link_clk_i) disable iff (rst_l) // RL5
		en_l && !stop_det && !start_det && state_reg == LINK_ADDR && scl_fall
			&& count_reg == BYTE_BITS && shift_reg[7:1] != SLAVE_ADDR
			|=> !sda_oe_o && state_reg == LINK_IDLE)
		else $error("foreign address acknowledged");
	addr_ack_a: assert property (@(posedge link_clk_i) disable iff (rst_l) // RL1
		en_l && !stop_det && !start_det && state_reg == LINK_ADDR && scl_fall
			&& count_reg == BYTE_BITS && shift_reg[7:1] == SLAVE_ADDR |=> sda_oe_o)
		else $error("own address not acknowledged");

	write_seen_c: cover property (@(posedge clock_i) disable iff (sys_rst_i) wr_control);
	read_seen_c: cover property (@(posedge clock_i) disable iff (sys_rst_i) rd_evt);
	boost_fault_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		fault_event_i && boost_mode_o);
	restart_c: cover property (@(posedge link_clk_i) disable iff (rst_l)
		start_det && state_reg != LINK_IDLE);

endmodule : charger_serial_port

`default_nettype wire

// file: shared/charger_pkg.sv
// Shared constants and types for the charger serial control port
package charger_pkg;

	// Bus identity and register map
	localparam logic [6:0] SLAVE_ADDR = 7'h6b;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h01;
	localparam logic [7:0] UNMAPPED_READ = 8'hff;

	// Status and mode register fields
	localparam int KICK_BIT = 7;
	localparam int BOOST_BIT = 6;
	localparam int STATE_HI = 5;
	localparam int STATE_LO = 4;
	localparam int SPARE_BIT = 3;
	localparam int FAULT_HI = 2;
	localparam int FAULT_LO = 0;

	// Charger control register fields
	localparam int SOFT_RST_BIT = 7;
	localparam int LIMIT_HI = 6;
	localparam int LIMIT_LO = 4;
	localparam int STAT_EN_BIT = 3;
	localparam int CUTOFF_BIT = 2;
	localparam int CHG_OFF_BIT = 1;
	localparam int INPUT_OFF_BIT = 0;

	// Reset values and fixed read-back values
	localparam logic BOOST_RST = 1'b0;
	localparam logic STAT_EN_RST = 1'b1;
	localparam logic CUTOFF_RST = 1'b1;
	localparam logic CHG_OFF_RST = 1'b0;
	localparam logic INPUT_OFF_RST = 1'b0;
	localparam logic KICK_READ = 1'b0;
	localparam logic SPARE_READ = 1'b0;
	localparam logic SOFT_RST_READ = 1'b1;
	localparam logic [2:0] FAULT_NONE = 3'h0;
	localparam logic [2:0] LIMIT_RST = 3'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Bit counts within a byte frame
	localparam logic [3:0] COUNT_RST = 4'h0;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_ADDR_ACK,
		LINK_WR_BYTE,
		LINK_WR_ACK,
		LINK_RD_BYTE,
		LINK_RD_ACK
	} link_state_type;

endpackage : charger_pkg

// file: src/sync_2ff.sv
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;

	// First stage is read by the second stage only
	always_ff @(posedge clk_i) begin
		meta_reg <= d_i;
		q_o <= meta_reg;
	end

endmodule : sync_2ff

`default_nettype wire

// file: src/fault_code_latch.sv
// First-fault code latch, cleared by a status read
`timescale 1ns/1ps
`default_nettype none

module fault_code_latch
	import charger_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic soft_rst_i,
	input wire logic set_i,
	input wire logic [2:0] code_i,
	input wire logic clear_i,
	output logic [2:0] code_o
);
	// A fault arriving with the clearing read is kept, never lost
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			code_o <= FAULT_NONE;
		end else if (clk_en_i) begin
			if (soft_rst_i) begin
				code_o <= FAULT_NONE;
			end else if (clear_i) begin
				code_o <= set_i ? code_i : FAULT_NONE; // RL17
			end else if (set_i && code_o == FAULT_NONE) begin
				code_o <= code_i; // RL17
			end
		end
	end

endmodule : fault_code_latch

`default_nettype wire

// file: sim/host_master.sv
// Bus master model that drives the two-wire serial lines
`timescale 1ns/1ps
`default_nettype none

module host_master #(
	parameter int Q = 36
) (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_low_o,
	output logic sda_low_o
);
	// Q is a quarter bit in clock cycles, slow enough for the link oversampler
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic tick;
		repeat (Q) @(negedge clock_i);
	endtask : tick
	// A repeated start must first release SDA and raise SCL
	task automatic start;
		sda_low_o = 1'b0;
		tick();
		scl_low_o = 1'b0;
		tick();
		sda_low_o = 1'b1;
		tick();
		scl_low_o = 1'b1;
		tick();
	endtask : start
	task automatic stop;
		sda_low_o = 1'b1;
		tick();
		scl_low_o = 1'b0;
		tick();
		sda_low_o = 1'b0;
		tick();
	endtask : stop
	// Data moves only while SCL is low; a released line reads the pull-up
	task automatic clk_bit(input logic b, output logic s);
		sda_low_o = ~b;
		tick();
		scl_low_o = 1'b0;
		tick();
		s = sda_i;
		tick();
		scl_low_o = 1'b1;
		tick();
	endtask : clk_bit
	task automatic xbyte(input logic [7:0] b, output logic ak);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, ak);
	endtask : xbyte
	task automatic rbyte(input logic nak, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(nak, s);
	endtask : rbyte
endmodule : host_master

`default_nettype wire

// file: sim/charger_serial_port_tb.sv
// Self-checking bench for the charger serial control port
`timescale 1ns/1ps
`default_nettype none

module charger_serial_port_tb
	import charger_pkg::*;
;
	logic clock_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clk_en = 1'b1;
	logic fault_event_i = 1'b0;
	logic [2:0] fault_code_i = 3'h0;
	logic [1:0] charge_state_i = 2'h1;
	logic [2:0] detected_limit_i = 3'h4;
	logic scl_low, sda_low, sda_oe, sda_out, kick, wd_off, dflt, boost;
	logic stat_en, cutoff, chg_off, in_off;
	logic [2:0] limit, fcode;
	wire scl_w = ~scl_low;
	wire sda_w = ~(sda_low | (sda_oe & ~sda_out));
	int err_total = 0;
	int comparisons = 0;
	int kick_cnt = 0;
	int off_cnt = 0;

	always #12.5 clock_i = ~clock_i;
	always #80 link_clk_i = ~link_clk_i;

	charger_serial_port dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
		.link_clk_i(link_clk_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_out),
		.sda_oe_o(sda_oe), .charge_state_i(charge_state_i), .fault_event_i(fault_event_i),
		.fault_code_i(fault_code_i), .detected_limit_i(detected_limit_i),
		.watchdog_kick_o(kick), .watchdog_off_o(wd_off), .default_mode_o(dflt),
		.boost_mode_o(boost), .input_limit_o(limit), .stat_enable_o(stat_en),
		.end_of_charge_cutoff_on_o(cutoff), .charge_disable_o(chg_off),
		.input_off_select_o(in_off), .fault_code_o(fcode));

	host_master host_u (.clock_i(clock_i), .sda_i(sda_w), .scl_low_o(scl_low),
		.sda_low_o(sda_low));

	always @(posedge clock_i) begin
		if (kick === 1'b1) kick_cnt++;
		if (wd_off === 1'b1) off_cnt++;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
		logic a0, a1, a2;
		host_u.start();
		host_u.xbyte({SLAVE_ADDR, 1'b0}, a0);
		host_u.xbyte(p, a1);
		host_u.xbyte(d, a2);
		host_u.stop();
		check({a0, a1, a2}, 8'h00);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] p, input logic [7:0] exp);
		logic a0, a1, a2;
		logic [7:0] d;
		host_u.start();
		host_u.xbyte({SLAVE_ADDR, 1'b0}, a0);
		host_u.xbyte(p, a1);
		host_u.start();
		host_u.xbyte({SLAVE_ADDR, 1'b1}, a2);
		host_u.rbyte(1'b1, d);
		host_u.stop();
		check({a0, a1, a2}, 8'h00);
		check(d, exp);
	endtask : rd_reg

	task automatic t_reset;
		check({dflt, boost, stat_en, cutoff, chg_off, in_off, sda_oe}, 8'h58);
		check({limit, fcode}, 8'h20);
		rd_reg(REG_CONTROL, 8'hcc);
	endtask : t_reset

	// Many data bytes in one write all land in the control register
	task automatic t_ctrl;
		logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
		logic a;
		host_u.start();
		host_u.xbyte({SLAVE_ADDR, 1'b0}, a);
		host_u.xbyte(REG_CONTROL, a);
		for (int i = 0; i < 6; i++) begin
			host_u.xbyte({1'b0, codes[i], 4'h3}, a);
			check(a, 8'h00);
			check(limit, codes[i]);
		end
		check({stat_en, cutoff, chg_off, in_off, dflt}, 8'h06);
		host_u.xbyte(8'h64, a);
		host_u.stop();
		rd_reg(REG_CONTROL, 8'he4);
	endtask : t_ctrl

	// Abandoned byte, unmapped read and unmapped write leave state untouched
	task automatic t_abort;
		logic a;
		host_u.start();
		host_u.xbyte({SLAVE_ADDR, 1'b0}, a);
		host_u.xbyte(REG_CONTROL, a);
		for (int i = 0; i < 4; i++) host_u.clk_bit(1'b0, a);
		host_u.stop();
		check({limit, stat_en, cutoff}, 8'h19);
		rd_reg(8'h05, UNMAPPED_READ);
		wr_reg(8'h05, 8'h00);
		check({limit, stat_en, cutoff, chg_off}, 8'h32);
	endtask : t_abort

	task automatic t_wrong_addr;
		logic a0, a1;
		host_u.start();
		host_u.xbyte({7'h6a, 1'b0}, a0);
		host_u.xbyte(REG_CONTROL, a1);
		host_u.stop();
		check({a0, a1}, 8'h03);
		check(limit, 3'h6);
	endtask : t_wrong_addr

	task automatic t_status;
		wr_reg(REG_STATUS, 8'hc0);
		check(8'(kick_cnt), 8'h01);
		check(boost, 1'b1);
		charge_state_i = 2'h2;
		rd_reg(REG_STATUS, 8'h60);
	endtask : t_status

	task automatic pulse_fault(input logic [2:0] c);
		@(negedge clock_i);
		fault_event_i = 1'b1;
		fault_code_i = c;
		@(negedge clock_i);
		fault_event_i = 1'b0;
		repeat (3) @(negedge clock_i);
	endtask : pulse_fault

	// Second fault must not overwrite the first; a status read clears it
	task automatic t_fault;
		logic a;
		logic [7:0] d;
		pulse_fault(3'h3);
		check({boost, fcode}, 8'h03);
		pulse_fault(3'h5);
		check(fcode, 3'h3);
		charge_state_i = 2'h3;
		rd_reg(REG_STATUS, 8'h33);
		check(fcode, FAULT_NONE);
		// Second byte of one read is fetched at the first byte's acknowledge
		host_u.start();
		host_u.xbyte({SLAVE_ADDR, 1'b1}, a);
		pulse_fault(3'h6);
		host_u.rbyte(1'b0, d);
		check(a, 8'h00);
		check(d, 8'h30);
		host_u.rbyte(1'b1, d);
		host_u.stop();
		check(d, 8'h36);
		check(fcode, FAULT_NONE);
	endtask : t_fault

	task automatic t_soft_reset;
		detected_limit_i = 3'h2;
		wr_reg(REG_CONTROL, 8'h80);
		check(8'(off_cnt), 8'h01);
		check({dflt, boost, stat_en, cutoff, chg_off, in_off}, 8'h2c);
		rd_reg(REG_CONTROL, 8'hac);
	endtask : t_soft_reset

	// Low enable freezes state; a reset mid-run restores defaults and the link
	task automatic t_freeze;
		clk_en = 1'b0;
		pulse_fault(3'h4);
		check(fcode, FAULT_NONE);
		clk_en = 1'b1;
		pulse_fault(3'h4);
		check(fcode, 3'h4);
		sys_rst_i = 1'b1;
		repeat (32) @(negedge clock_i);
		sys_rst_i = 1'b0;
		repeat (30) @(negedge clock_i);
		check({dflt, boost, stat_en, cutoff, chg_off, in_off, sda_oe}, 8'h58);
		check({limit, fcode}, 8'h10);
		rd_reg(REG_CONTROL, 8'hac);
	endtask : t_freeze

	task automatic finish_test;
		if (err_total == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	// Link side needs reset to pass its synchroniser, so it is held longer
	initial begin
		repeat (32) @(negedge clock_i);
		sys_rst_i = 1'b0;
		repeat (30) @(negedge clock_i);
		t_reset();
		t_ctrl();
		t_abort();
		t_wrong_addr();
		t_status();
		t_fault();
		t_soft_reset();
		t_freeze();
		finish_test();
	end

	initial begin
		repeat (100000) @(posedge clock_i);
		err_total++;
		finish_test();
	end
endmodule : charger_serial_port_tb

`default_nettype wire
